// ===== pxb_consts.vh
// Constants for the port and external memory bus block.
`ifndef PXB_CONSTS_VH
`define PXB_CONSTS_VH

// Fetch address after reset and the first external address in ROM mode.
`define PXB_RESET_VECTOR  16'h000C
`define PXB_ROM_LIMIT     16'h2000

// Reset timing, counted in input_clock_period units (one clock each).
`define PXB_FILTER_CLKS   3'h4
`define PXB_LATCH_CLKS    3'h5
`define PXB_HOLD_CLKS     5'h12

// Data strobe phase length and the extra wait of extended timing.
`define PXB_DS_CLKS       4'h6
`define PXB_EXT_CLKS      4'h4
`define PXB_DS_LEAD       4'h1

// Port 1 modes.
`define PXB_P1_INPUT      2'h0
`define PXB_P1_OUTPUT     2'h1
`define PXB_P1_ADDR_DATA  2'h2

// Layout of the synchronised pin vector.
`define PXB_SYNC_W        29
`define PXB_SI_RST        0
`define PXB_SI_ROM        1
`define PXB_SI_P31        2
`define PXB_SI_P32        3
`define PXB_SI_P33        4
`define PXB_SI_P0         12:5
`define PXB_SI_P1         20:13
`define PXB_SI_P2         28:21

// Bus cycle states.
`define PXB_S_IDLE        3'h0
`define PXB_S_ADDR        3'h1
`define PXB_S_AHOLD       3'h2
`define PXB_S_DATA        3'h3
`define PXB_S_END         3'h4

// Handshake states.
`define PXB_H_IDLE        2'h0
`define PXB_H_WAIT        2'h1
`define PXB_H_ACK         2'h2

`endif

// ===== pxb_ext_mem.sv
// Behavioural external memory on the multiplexed Port 1 bus.
`timescale 1ns/1ps
module pxb_ext_mem (
    input  wire        clock,
    input  wire        address_strobe_n,
    input  wire        data_strobe_n,
    input  wire        read_write,
    input  wire [7:0]  p0_pin_out,
    input  wire [7:0]  p1_pin_out,
    input  wire [7:0]  p1_pin_oe_n,
    output wire [7:0]  p1_pin_in,
    output reg  [15:0] lat_addr
);
    reg  [7:0] mem_q [0:255];
    reg  [7:0] last_q = 8'h00;
    wire       drive = !data_strobe_n && read_write && p1_pin_oe_n == 8'hFF;
    always @(posedge address_strobe_n) lat_addr <= {p0_pin_out, p1_pin_out};
    // Write data is taken as the data strobe falls.
    always @(negedge data_strobe_n) if (!read_write) mem_q[lat_addr[7:0]] <= p1_pin_out;
    // A released bus shows the inverse of the last byte, never a held value.
    always @(posedge clock) if (drive) last_q <= mem_q[lat_addr[7:0]];
    assign p1_pin_in = (p1_pin_oe_n == 8'h00) ? p1_pin_out :
                       drive ? mem_q[lat_addr[7:0]] : ~last_q;
endmodule

// ===== pxb_handshake.v
// Two-wire handshake for one port: data available plus ready.
`timescale 1ns/1ps
`include "pxb_consts.vh"

module pxb_handshake (
    input  wire       clock,
    input  wire       sys_rst,
    input  wire       hs_en,
    input  wire       port_out,
    input  wire       hs_in,
    input  wire       wr_pulse,
    input  wire       rd_pulse,
    input  wire [7:0] data_in,
    output reg        hs_out,
    output reg  [7:0] data_q,
    output reg        full_q
);

    reg [1:0] st_q;

    // Output direction: hs_out is data available (low active), hs_in is ready.
    // Input direction: hs_in is data available (low active), hs_out is ready.
    always @(posedge clock) begin
        if (sys_rst || !hs_en) begin
            st_q   <= `PXB_H_IDLE;
            hs_out <= 1'b1;
            full_q <= 1'b0;
            data_q <= 8'h00;
        end else if (port_out) begin
            case (st_q)
                `PXB_H_IDLE: begin
                    if (wr_pulse) begin
                        st_q   <= `PXB_H_WAIT;
                        full_q <= 1'b1;
                    end
                end
                `PXB_H_WAIT: begin
                    // Only flag new data once the peer says it is ready.
                    if (hs_in) begin
                        hs_out <= 1'b0;
                        st_q   <= `PXB_H_ACK;
                    end
                end
                `PXB_H_ACK: begin
                    if (!hs_in) begin
                        hs_out <= 1'b1;
                        full_q <= 1'b0;
                        st_q   <= `PXB_H_IDLE;
                    end
                end
                default: st_q <= `PXB_H_IDLE;
            endcase
        end else begin
            case (st_q)
                `PXB_H_IDLE: begin
                    hs_out <= 1'b1;
                    if (!hs_in && !full_q) begin
                        data_q <= data_in;
                        full_q <= 1'b1;
                        hs_out <= 1'b0;
                        st_q   <= `PXB_H_ACK;
                    end else if (rd_pulse) begin
                        full_q <= 1'b0;
                    end
                end
                `PXB_H_ACK: begin
                    // Ready returns only after the peer lets go and software has read.
                    if (rd_pulse) begin
                        full_q <= 1'b0;
                    end
                    if (hs_in && (!full_q || rd_pulse)) begin
                        hs_out <= 1'b1;
                        st_q   <= `PXB_H_IDLE;
                    end
                end
                default: st_q <= `PXB_H_IDLE;
            endcase
        end
    end

endmodule

// ===== pxb_port_bus.v
// Ports 0, 1 and 2 with external memory bus, strobes and reset sequence.
// Operation
// - Low ROM-disable pin selects external fetch; open or high keeps internal ROM.
// - Data strobe goes low exactly once for every external read or write.
// - Write data is on the bus before data strobe falls.
// - Address strobe pulses once per external bus cycle; low address leaves on Port 1.
// - Address is valid at the rising edge of address strobe.
// - Software can float both strobes, read/write, Port 0 and Port 1 together.
// - Read/write is low for writes and high for reads.
// - Reset pulses shorter than four input clocks are ignored.
// - Internal reset latches on fifth clock, holds 18 clocks or pin duration.
// - During reset data strobe stays low and address strobe toggles every clock.
// - After reset the fetch address is 000C.
// - Port 0 has eight lines; each nibble is I/O or address output.
// - Port 0 handshake uses P32 and P35.
// - Upper nibble direction sets handshake roles; nibbles must match directions.
// - Port 0 carries A11-A8 on low nibble or A15-A8 on both.
// - ROMless reset makes Port 0 all address and enables extended timing.
// - Port 1 is byte input or output, or multiplexed address/data.
// - Port 1 handshake uses P33 and P34; as output P33 is ready and P34 data available.
// - Accesses at 8192 and above go external through Port 1.
// - Bus sharing drives request on P34 and takes acknowledge on P33.
// - Port 2 is bit-direction I/O, optional open drain, handshake on P31/P36.
`timescale 1ns/1ps
`include "pxb_consts.vh"

module pxb_port_bus (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        reset_n_pin,
    input  wire        internal_rom_disable_n,
    output reg         core_reset,
    output reg         romless_mode,
    output reg  [15:0] boot_addr,
    input  wire        mem_req,
    input  wire        mem_write,
    input  wire [15:0] mem_addr,
    input  wire [7:0]  mem_wdata,
    output reg         mem_ack,
    output reg         mem_internal,
    output reg  [7:0]  mem_rdata,
    input  wire        cfg_load,
    input  wire        p0_lo_dir_out,
    input  wire        p0_hi_dir_out,
    input  wire        p0_lo_addr,
    input  wire        p0_hi_addr,
    input  wire        ext_timing,
    input  wire [1:0]  p1_mode,
    input  wire [7:0]  p2_dir_out,
    input  wire        p2_open_drain,
    input  wire        hs0_en,
    input  wire        hs1_en,
    input  wire        hs2_en,
    input  wire        bus_share_en,
    input  wire        bus_float,
    input  wire        p0_wr,
    input  wire        p1_wr,
    input  wire        p2_wr,
    input  wire [7:0]  port_wdata,
    input  wire        p0_rd,
    input  wire        p1_rd,
    input  wire        p2_rd,
    output reg  [7:0]  p0_rdata,
    output reg  [7:0]  p1_rdata,
    output reg  [7:0]  p2_rdata,
    output reg  [2:0]  hs_full,
    input  wire [7:0]  p0_pin_in,
    output reg  [7:0]  p0_pin_out,
    output reg  [7:0]  p0_pin_oe_n,
    input  wire [7:0]  p1_pin_in,
    output reg  [7:0]  p1_pin_out,
    output reg  [7:0]  p1_pin_oe_n,
    input  wire [7:0]  p2_pin_in,
    output reg  [7:0]  p2_pin_out,
    output reg  [7:0]  p2_pin_oe_n,
    output reg         address_strobe_n,
    output reg         address_strobe_oe_n,
    output reg         data_strobe_n,
    output reg         data_strobe_oe_n,
    output reg         read_write,
    output reg         read_write_oe_n,
    input  wire        p31_in,
    input  wire        p32_in,
    input  wire        p33_in,
    output reg         p34_out,
    output reg         p35_out,
    output reg         p36_out
);

    // Three-stage pin synchronisers; a bit changes once stages two and three agree.
    wire [`PXB_SYNC_W-1:0] raw_in;
    reg  [`PXB_SYNC_W-1:0] s1_q, s2_q, s3_q, pin_q;
    assign raw_in = {p2_pin_in, p1_pin_in, p0_pin_in, p33_in, p32_in, p31_in,
                     internal_rom_disable_n, reset_n_pin};
    always @(posedge clock) begin
        if (sys_rst) begin
            s1_q  <= {`PXB_SYNC_W{1'b1}};
            s2_q  <= {`PXB_SYNC_W{1'b1}};
            s3_q  <= {`PXB_SYNC_W{1'b1}};
            pin_q <= {`PXB_SYNC_W{1'b1}};
        end else begin
            s1_q  <= raw_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
        end
    end
    wire rst_pin_s = pin_q[`PXB_SI_RST];
    wire ack_s     = pin_q[`PXB_SI_P33];

    // Reset filter, latch delay and hold counter.
    reg [2:0] filt_q, lat_q;
    reg [4:0] hold_q;
    reg       int_rst_q, as_tog_q;
    always @(posedge clock) begin
        if (sys_rst) begin
            filt_q    <= 3'h0;
            lat_q     <= 3'h0;
            hold_q    <= `PXB_HOLD_CLKS;
            int_rst_q <= 1'b1;
            as_tog_q  <= 1'b1;
        end else begin
            if (rst_pin_s)
                filt_q <= 3'h0;
            else if (filt_q != `PXB_FILTER_CLKS)
                filt_q <= filt_q + 3'h1;
            as_tog_q <= int_rst_q ? ~as_tog_q : 1'b1;
            if (!int_rst_q) begin
                if (lat_q != 3'h0 || filt_q == `PXB_FILTER_CLKS) begin
                    lat_q <= lat_q + 3'h1;
                    if (lat_q + 3'h1 == `PXB_LATCH_CLKS) begin
                        int_rst_q <= 1'b1;
                        hold_q    <= `PXB_HOLD_CLKS;
                        lat_q     <= 3'h0;
                    end
                end
            end else begin
                if (hold_q != 5'h00)
                    hold_q <= hold_q - 5'h01;
                else if (rst_pin_s)
                    int_rst_q <= 1'b0;
            end
        end
    end

    // Strap and port configuration; defaults depend on the ROM mode strap.
    reg romless_q, lo_addr_q, hi_addr_q, ext_q;
    always @(posedge clock) begin
        if (sys_rst) begin
            romless_q <= 1'b0;
            lo_addr_q <= 1'b0;
            hi_addr_q <= 1'b0;
            ext_q     <= 1'b0;
        end else if (int_rst_q) begin
            romless_q <= ~pin_q[`PXB_SI_ROM];
            lo_addr_q <= romless_q;
            hi_addr_q <= romless_q;
            ext_q     <= romless_q;
        end else if (cfg_load) begin
            lo_addr_q <= p0_lo_addr;
            hi_addr_q <= p0_hi_addr;
            ext_q     <= ext_timing;
        end
    end

    // External bus cycle sequencer.
    reg [2:0]  st_q;
    reg [3:0]  cnt_q;
    reg [15:0] addr_q;
    reg [7:0]  wdat_q;
    reg        wr_q;
    wire [3:0] ds_len   = `PXB_DS_CLKS + (ext_q ? `PXB_EXT_CLKS : 4'h0);
    // Software float, also forced while another master owns the bus.
    wire       float_w  = !int_rst_q && (bus_float || (bus_share_en && !ack_s));
    // Only ROM mode keeps low addresses on chip.
    wire       on_chip  = !romless_q && (mem_addr < `PXB_ROM_LIMIT);
    wire       take_req = mem_req && !mem_ack && !int_rst_q && st_q == `PXB_S_IDLE;
    always @(posedge clock) begin
        if (sys_rst || int_rst_q) begin
            st_q         <= `PXB_S_IDLE;
            cnt_q        <= 4'h0;
            addr_q       <= `PXB_RESET_VECTOR;
            wdat_q       <= 8'h00;
            wr_q         <= 1'b0;
            mem_ack      <= 1'b0;
            mem_internal <= 1'b0;
            mem_rdata    <= 8'h00;
        end else begin
            mem_ack      <= 1'b0;
            mem_internal <= 1'b0;
            case (st_q)
                `PXB_S_IDLE: begin
                    if (take_req && on_chip) begin
                        mem_ack      <= 1'b1;
                        mem_internal <= 1'b1;
                    end else if (take_req && !float_w) begin
                        addr_q <= mem_addr;
                        wdat_q <= mem_wdata;
                        wr_q   <= mem_write;
                        st_q   <= `PXB_S_ADDR;
                    end
                end
                `PXB_S_ADDR:  st_q <= `PXB_S_AHOLD;
                `PXB_S_AHOLD: begin
                    cnt_q <= 4'h0;
                    st_q  <= `PXB_S_DATA;
                end
                `PXB_S_DATA: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == ds_len) begin
                        mem_rdata <= pin_q[`PXB_SI_P1];
                        st_q      <= `PXB_S_END;
                    end
                end
                `PXB_S_END: begin
                    mem_ack <= 1'b1;
                    st_q    <= `PXB_S_IDLE;
                end
                default: st_q <= `PXB_S_IDLE;
            endcase
        end
    end

    // Port data registers written by the core.
    reg [7:0] p0_dat_q, p1_dat_q, p2_dat_q;
    always @(posedge clock) begin
        if (sys_rst) begin
            p0_dat_q <= 8'h00;
            p1_dat_q <= 8'h00;
            p2_dat_q <= 8'h00;
        end else begin
            if (p0_wr) p0_dat_q <= port_wdata;
            if (p1_wr) p1_dat_q <= port_wdata;
            if (p2_wr) p2_dat_q <= port_wdata;
        end
    end

    // Handshake only with matching nibble directions and no address nibble.
    wire hs0_on = hs0_en && (p0_lo_dir_out == p0_hi_dir_out) && !lo_addr_q && !hi_addr_q;
    wire p1_io  = (p1_mode != `PXB_P1_ADDR_DATA);
    wire hs1_on = hs1_en && p1_io && !bus_share_en;
    wire p1_out = (p1_mode == `PXB_P1_OUTPUT);
    wire [2:0] hs_out_w;
    wire [7:0] hs0_dat, hs1_dat, hs2_dat;
    wire [2:0] hs_full_w;

    pxb_handshake u_hs0 (
        .clock    (clock),
        .sys_rst  (sys_rst || int_rst_q),
        .hs_en    (hs0_on),
        .port_out (p0_hi_dir_out),
        .hs_in    (pin_q[`PXB_SI_P32]),
        .wr_pulse (p0_wr),
        .rd_pulse (p0_rd),
        .data_in  (pin_q[`PXB_SI_P0]),
        .hs_out   (hs_out_w[0]),
        .data_q   (hs0_dat),
        .full_q   (hs_full_w[0])
    );
    pxb_handshake u_hs1 (
        .clock    (clock),
        .sys_rst  (sys_rst || int_rst_q),
        .hs_en    (hs1_on),
        .port_out (p1_out),
        .hs_in    (pin_q[`PXB_SI_P33]),
        .wr_pulse (p1_wr),
        .rd_pulse (p1_rd),
        .data_in  (pin_q[`PXB_SI_P1]),
        .hs_out   (hs_out_w[1]),
        .data_q   (hs1_dat),
        .full_q   (hs_full_w[1])
    );
    // Port 2 lines P31/P36, roles from P27
    pxb_handshake u_hs2 (
        .clock    (clock),
        .sys_rst  (sys_rst || int_rst_q),
        .hs_en    (hs2_en),
        .port_out (p2_dir_out[7]),
        .hs_in    (pin_q[`PXB_SI_P31]),
        .wr_pulse (p2_wr),
        .rd_pulse (p2_rd),
        .data_in  (pin_q[`PXB_SI_P2]),
        .hs_out   (hs_out_w[2]),
        .data_q   (hs2_dat),
        .full_q   (hs_full_w[2])
    );

    // Next pin values; every output is registered below for clean edges.
    wire in_cyc  = (st_q != `PXB_S_IDLE);
    wire ds_low  = (st_q == `PXB_S_DATA) && (cnt_q >= `PXB_DS_LEAD);
    wire wr_data = wr_q && ((st_q == `PXB_S_DATA) || (st_q == `PXB_S_END));
    wire adr_ph  = (st_q == `PXB_S_ADDR) || (st_q == `PXB_S_AHOLD);
    reg  [7:0] p0_out_d, p0_oe_d, p1_out_d, p1_oe_d;
    always @* begin
        p0_out_d = p0_dat_q;
        p0_oe_d  = {{4{~p0_hi_dir_out}}, {4{~p0_lo_dir_out}}};
        if (lo_addr_q) begin
            p0_out_d[3:0] = addr_q[11:8];
            p0_oe_d[3:0]  = 4'h0;
        end
        if (hi_addr_q) begin
            p0_out_d[7:4] = addr_q[15:12];
            p0_oe_d[7:4]  = 4'h0;
        end
        p1_out_d = p1_dat_q;
        p1_oe_d  = p1_out ? 8'h00 : 8'hFF;
        if (!p1_io) begin
            p1_out_d = wr_data ? wdat_q : addr_q[7:0];
            p1_oe_d  = (adr_ph || wr_data) ? 8'h00 : 8'hFF;
        end
        if (float_w) begin
            p0_oe_d = 8'hFF;
            p1_oe_d = 8'hFF;
        end
    end

    // Pin registers and read-back registers.
    always @(posedge clock) begin
        if (sys_rst) begin
            {p0_pin_out, p1_pin_out, p2_pin_out} <= 24'h000000;
            {p0_pin_oe_n, p1_pin_oe_n, p2_pin_oe_n} <= 24'hFFFFFF;
            address_strobe_n    <= 1'b1;
            address_strobe_oe_n <= 1'b0;
            data_strobe_n       <= 1'b1;
            data_strobe_oe_n    <= 1'b0;
            read_write          <= 1'b1;
            read_write_oe_n     <= 1'b0;
            {p34_out, p35_out, p36_out} <= 3'h7;
            {p0_rdata, p1_rdata, p2_rdata} <= 24'h000000;
            hs_full      <= 3'h0;
            core_reset   <= 1'b1;
            romless_mode <= 1'b0;
            boot_addr    <= `PXB_RESET_VECTOR;
        end else begin
            p0_pin_out  <= p0_out_d;
            p0_pin_oe_n <= p0_oe_d;
            p1_pin_out  <= p1_out_d;
            p1_pin_oe_n <= p1_oe_d;
            // Open drain drives only the zeros
            p2_pin_out  <= p2_open_drain ? 8'h00 : p2_dat_q;
            p2_pin_oe_n <= p2_open_drain ? ~(p2_dir_out & ~p2_dat_q) : ~p2_dir_out;
            address_strobe_n <= int_rst_q ? as_tog_q : (st_q != `PXB_S_ADDR);
            data_strobe_n    <= int_rst_q ? 1'b0 : ~ds_low;
            read_write       <= ~(in_cyc && wr_q);
            address_strobe_oe_n <= float_w;
            data_strobe_oe_n    <= float_w;
            read_write_oe_n     <= float_w;
            p34_out <= bus_share_en ? ~(mem_req && !ack_s) : hs_out_w[1];
            p35_out <= hs_out_w[0];
            p36_out <= hs_out_w[2];
            p0_rdata <= (hs0_on && !p0_hi_dir_out) ? hs0_dat : pin_q[`PXB_SI_P0];
            p1_rdata <= (hs1_on && !p1_out) ? hs1_dat : pin_q[`PXB_SI_P1];
            p2_rdata <= (hs2_en && !p2_dir_out[7]) ? hs2_dat : pin_q[`PXB_SI_P2];
            hs_full      <= hs_full_w;
            core_reset   <= int_rst_q;
            romless_mode <= romless_q;
            boot_addr    <= `PXB_RESET_VECTOR;
        end
    end

endmodule

// ===== pxb_port_bus_bench.sv
// Self-checking bench for the port and external memory bus block.
`timescale 1ns/1ps
module pxb_port_bus_bench;
    reg         clock, sys_rst, reset_n_pin, internal_rom_disable_n, mem_req, mem_write;
    reg         cfg_load, p0_lo_dir_out, p0_hi_dir_out, p0_lo_addr, p0_hi_addr, ext_timing;
    reg         p2_open_drain, hs0_en, hs1_en, hs2_en, bus_share_en, bus_float, p0_wr;
    reg         p1_wr, p2_wr, p0_rd, p1_rd, p2_rd, p31_in, p32_in, p33_in, int_q;
    reg  [1:0]  p1_mode;
    reg  [7:0]  mem_wdata, p2_dir_out, port_wdata, p0_pin_in, p2_pin_in, rd;
    reg  [15:0] mem_addr;
    wire        core_reset, romless_mode, mem_ack, mem_internal, p34_out, p35_out, p36_out;
    wire        address_strobe_n, address_strobe_oe_n, data_strobe_n, data_strobe_oe_n;
    wire        read_write, read_write_oe_n;
    wire [2:0]  hs_full;
    wire [7:0]  mem_rdata, p0_rdata, p1_rdata, p2_rdata, p0_pin_out, p0_pin_oe_n, p1_pin_in;
    wire [7:0]  p1_pin_out, p1_pin_oe_n, p2_pin_out, p2_pin_oe_n;
    wire [15:0] boot_addr, lat_addr;
    integer     error_cnt, checks_done, n;
    pxb_port_bus u_dut (.*);
    pxb_ext_mem u_mem (.*);
    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task chk(input [95:0] what, input [15:0] exp, input [15:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // Inputs move one nanosecond after the rising edge.
    task tick(input integer k);
        begin
            repeat (k) @(posedge clock);
            #1;
        end
    endtask
    task wait_rel;
        begin
            n = 0;
            while (core_reset !== 1'b0 && n < 200) begin
                tick(1);
                n = n + 1;
            end
        end
    endtask
    task cfg;
        begin
            cfg_load = 1'b1;
            tick(1);
            cfg_load = 1'b0;
        end
    endtask
    // The request is held until the acknowledge edge and dropped in that cycle.
    task access(input wr, input [15:0] a, input [7:0] d);
        begin
            tick(1);
            mem_write = wr;
            mem_addr = a;
            mem_wdata = d;
            mem_req = 1'b1;
            n = 0;
            while (mem_ack !== 1'b1 && n < 40) begin
                tick(1);
                n = n + 1;
            end
            rd = mem_rdata;
            int_q = mem_internal;
            mem_req = 1'b0;
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // A hang is cut short well past the expected run length.
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        print_verdict;
    end
    initial begin
        {mem_req, mem_write, cfg_load, p0_lo_dir_out, p0_hi_dir_out, p0_lo_addr} = 0;
        {p0_hi_addr, ext_timing, p2_open_drain, hs0_en, hs1_en, hs2_en, bus_share_en} = 0;
        {bus_float, p0_wr, p1_wr, p2_wr, p0_rd, p1_rd, p2_rd, p31_in, p32_in, p33_in} = 0;
        {mem_wdata, p2_dir_out, port_wdata, p0_pin_in, p2_pin_in, mem_addr} = 0;
        {reset_n_pin, internal_rom_disable_n, p1_mode, error_cnt, checks_done} = {4'hE, 64'h0};
        sys_rst = 1'b1;
        tick(20);
        sys_rst = 1'b0;
        tick(3);
        chk("in reset", 16'h0001, core_reset);
        wait_rel;
        chk("boot addr", 16'h000C, boot_addr);
        chk("rom mode", 16'h0000, romless_mode);
        access(1'b0, 16'h0100, 8'h00);
        chk("on chip", 16'h0001, int_q);
        access(1'b1, 16'h2055, 8'hA5);
        chk("wr latency", 16'h000B, n);
        access(1'b0, 16'h2055, 8'h00);
        chk("rd data", 16'h00A5, rd);
        p0_lo_addr = 1'b1;
        cfg;
        access(1'b1, 16'h2A3C, 8'h5A);
        chk("a11 a8", 16'h000A, lat_addr[11:8]);
        ext_timing = 1'b1;
        cfg;
        access(1'b0, 16'h2A3C, 8'h00);
        chk("ext latency", 16'h000F, n);
        chk("ext rd data", 16'h005A, rd);
        ext_timing = 1'b0;
        cfg;
        bus_share_en = 1'b1;
        mem_req = 1'b1;
        tick(6);
        chk("bus request", 16'h0000, p34_out);
        p33_in = 1'b1;
        access(1'b0, 16'h2055, 8'h00);
        chk("shared rd", 16'h00A5, rd);
        bus_share_en = 1'b0;
        bus_float = 1'b1;
        tick(3);
        chk("float", 16'h0007, {address_strobe_oe_n, data_strobe_oe_n, read_write_oe_n});
        bus_float = 1'b0;
        reset_n_pin = 1'b0;
        tick(2);
        reset_n_pin = 1'b1;
        tick(20);
        chk("short pulse", 16'h0000, core_reset);
        internal_rom_disable_n = 1'b0;
        reset_n_pin = 1'b0;
        tick(30);
        chk("pin reset", 16'h0001, core_reset);
        reset_n_pin = 1'b1;
        wait_rel;
        chk("romless", 16'h0001, romless_mode);
        chk("p0 address", 16'h0000, p0_pin_oe_n);
        access(1'b1, 16'h0123, 8'h77);
        chk("romless lat", 16'h000F, n);
        chk("full addr", 16'h0123, lat_addr);
        p1_mode = 2'h1;
        port_wdata = 8'h3C;
        p1_wr = 1'b1;
        tick(1);
        p1_wr = 1'b0;
        tick(2);
        chk("p1 output", 16'h003C, {p1_pin_oe_n, p1_pin_out});
        print_verdict;
    end
endmodule

// ===== pxb_port_bus_props.sv
// Checker for the port and external memory bus block.
`timescale 1ns/1ps
`include "pxb_consts.vh"
module pxb_port_bus_props (
    input wire        clock,
    input wire        sys_rst,
    input wire        reset_n_pin,
    input wire        core_reset,
    input wire        romless_mode,
    input wire [15:0] boot_addr,
    input wire        mem_req,
    input wire        mem_write,
    input wire [15:0] mem_addr,
    input wire [7:0]  mem_wdata,
    input wire        mem_ack,
    input wire        mem_internal,
    input wire        bus_float,
    input wire [7:0]  p0_pin_oe_n,
    input wire [7:0]  p1_pin_out,
    input wire [7:0]  p1_pin_oe_n,
    input wire        address_strobe_n,
    input wire        address_strobe_oe_n,
    input wire        data_strobe_n,
    input wire        data_strobe_oe_n,
    input wire        read_write,
    input wire        read_write_oe_n
);
    reg [5:0] hi_q;
    reg [2:0] low_q;
    reg [4:0] recent_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Count reset-high cycles and remember a recent pin pulse of four clocks.
    always @(posedge clock) begin
        hi_q <= (sys_rst || !core_reset) ? 6'h00 : (hi_q == 6'h3F ? hi_q : hi_q + 6'h01);
        low_q <= (sys_rst || reset_n_pin) ? 3'h0 : (low_q == 3'h7 ? low_q : low_q + 3'h1);
        recent_q <= sys_rst ? 5'h00 : (low_q == 3'h3 && !reset_n_pin) ? 5'h1F :
                    (recent_q != 5'h00 ? recent_q - 5'h01 : 5'h00);
    end
    property p_filter; $rose(core_reset) |-> recent_q != 5'h00; endproperty
    a_filter: assert property (p_filter) else $error("Reset from a short pulse.");
    property p_hold; $fell(core_reset) |-> hi_q >= 6'h12; endproperty
    a_hold: assert property (p_hold) else $error("Internal reset too short.");
    property p_rst_strobes;
        core_reset && $past(core_reset) && !$past(sys_rst) && !$past(sys_rst, 2) &&
        !$past(sys_rst, 3) |-> !data_strobe_n && address_strobe_n != $past(address_strobe_n);
    endproperty
    a_rst_strobes: assert property (p_rst_strobes) else $error("Reset strobes wrong.");
    property p_boot; !core_reset |-> boot_addr == `PXB_RESET_VECTOR; endproperty
    a_boot: assert property (p_boot) else $error("Boot address wrong.");
    property p_onchip;
        mem_ack |-> mem_internal == (!romless_mode && mem_addr < `PXB_ROM_LIMIT);
    endproperty
    a_onchip: assert property (p_onchip) else $error("On-chip decode wrong.");
    property p_nobus; mem_internal |-> data_strobe_n && $past(data_strobe_n); endproperty
    a_nobus: assert property (p_nobus) else $error("Strobe on on-chip access.");
    property p_rw; !core_reset && !data_strobe_n && mem_req |-> read_write == !mem_write;
    endproperty
    a_rw: assert property (p_rw) else $error("Read/write level wrong.");
    property p_wdata;
        !core_reset && mem_req && mem_write && $fell(data_strobe_n) |->
        p1_pin_oe_n == 8'h00 && p1_pin_out == mem_wdata;
    endproperty
    a_wdata: assert property (p_wdata) else $error("Write data late.");
    property p_addr;
        !core_reset && mem_req && $rose(address_strobe_n) |->
        p1_pin_oe_n == 8'h00 && p1_pin_out == mem_addr[7:0];
    endproperty
    a_addr: assert property (p_addr) else $error("Address not valid.");
    property p_float;
        bus_float && $past(bus_float) && $past(bus_float, 2) |-> address_strobe_oe_n &&
        data_strobe_oe_n && read_write_oe_n && (p0_pin_oe_n & p1_pin_oe_n) == 8'hFF;
    endproperty
    a_float: assert property (p_float) else $error("Bus not floated.");
    c_write: cover property (mem_write && $fell(data_strobe_n));
    c_float: cover property (bus_float && address_strobe_oe_n);
    c_pin_rst: cover property ($rose(core_reset));
endmodule
bind pxb_port_bus pxb_port_bus_props u_props (.*);
